// ===== rtl/cwl_defs.svh
`ifndef CWL_DEFS_SVH
`define CWL_DEFS_SVH
// ****************************************
// sizes and addresses
// ****************************************
`define CWL_WORD_W 24
`define CWL_NUM_WORDS 4
`define CWL_LAST_IDX 2'h3
`define CWL_TOP_LARGE 24'h0157fe
`define CWL_TOP_SMALL 24'h00abfe
`define CWL_CFG_BASE 24'hf80000
`define CWL_CFG_SPACE_BIT 23
`define CWL_CFG_SPAN 24'h000008
// ****************************************
// first configuration word layout
// ****************************************
`define CWL_UPPER_HI 23
`define CWL_UPPER_LO 16
`define CWL_UPPER_ONES 8'hff
`define CWL_UPPER_NOP 8'h00
`define CWL_LOW_HI 15
`define CWL_B_SCAN 14
`define CWL_B_GCP 13
`define CWL_B_GENERAL_WRITE_PROTECT_N 12
`define CWL_B_DEBUG 11
`define CWL_B_RETENTION_REGULATOR_CFG 10
`define CWL_F_EMU_HI 9
`define CWL_F_EMU_LO 8
`define CWL_F_WMODE_HI 7
`define CWL_F_WMODE_LO 6
`define CWL_B_WINDOW_WATCHDOG_OFF 5
`define CWL_B_PSA 4
`define CWL_F_WPS_HI 3
`define CWL_F_WPS_LO 0
// ****************************************
// field codes and ratios
// ****************************************
`define CWL_EMU_PAIR1 2'h3
`define CWL_EMU_PAIR2 2'h2
`define CWL_EMU_PAIR3 2'h1
`define CWL_EMU_RSVD 2'h0
`define CWL_WDT_ALWAYS 2'h3
`define CWL_WDT_SOFT 2'h2
`define CWL_WDT_RUNONLY 2'h1
`define CWL_WDT_OFF 2'h0
`define CWL_PRESCALE_HI 8'h80
`define CWL_PRESCALE_LO 8'h20
`define CWL_POST_ONE 16'h0001
`endif

// ===== rtl/cwl_pkg.sv
`default_nettype none
package cwl_pkg;
   // ****************************************
   // decoded first configuration word
   // ****************************************
   typedef struct packed {
      logic scan_port_enable;
      logic code_protect;
      logic write_protect;
      logic debug_boot;
      logic retention_fw_ctl;
      logic [2:0] emu_pair;
      logic [1:0] watchdog_mode_cfg;
      logic window_sel;
      logic [7:0] prescale_ratio;
      logic [15:0] postscale_ratio;
      logic cfg_error;
   } cwl_cfg_t;

   typedef enum logic {
      CWL_FETCH,
      CWL_RUN
   } cwl_state_t;
endpackage
`default_nettype wire

// ===== rtl/cwl_word_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "cwl_defs.svh"
module cwl_word_decode (
   input wire logic [23:0] word_i,
   output cwl_pkg::cwl_cfg_t cfg_o
);
   // ****************************************
   // field decode, a '1' is the unprogrammed default
   // ****************************************
   logic [1:0] emu;
   logic [1:0] wmode;
   assign emu = word_i[`CWL_F_EMU_HI:`CWL_F_EMU_LO];
   assign wmode = word_i[`CWL_F_WMODE_HI:`CWL_F_WMODE_LO];
   assign cfg_o.scan_port_enable = word_i[`CWL_B_SCAN];
   assign cfg_o.code_protect = ~word_i[`CWL_B_GCP];
   assign cfg_o.write_protect = ~word_i[`CWL_B_GENERAL_WRITE_PROTECT_N];
   assign cfg_o.debug_boot = ~word_i[`CWL_B_DEBUG];
   assign cfg_o.retention_fw_ctl = ~word_i[`CWL_B_RETENTION_REGULATOR_CFG];
   assign cfg_o.emu_pair = {emu == `CWL_EMU_PAIR3, emu == `CWL_EMU_PAIR2, emu == `CWL_EMU_PAIR1};
   assign cfg_o.watchdog_mode_cfg = wmode;
   assign cfg_o.window_sel = ~word_i[`CWL_B_WINDOW_WATCHDOG_OFF];
   assign cfg_o.prescale_ratio = word_i[`CWL_B_PSA] ? `CWL_PRESCALE_HI : `CWL_PRESCALE_LO;
   assign cfg_o.postscale_ratio = `CWL_POST_ONE << word_i[`CWL_F_WPS_HI:`CWL_F_WPS_LO];
   // reserved pin code, or windowed watchdog with watchdog off
   assign cfg_o.cfg_error = (emu == `CWL_EMU_RSVD) || (~word_i[`CWL_B_WINDOW_WATCHDOG_OFF] && wmode == `CWL_WDT_OFF);
endmodule
`default_nettype wire

// ===== rtl/cwl_wdt_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "cwl_defs.svh"
module cwl_wdt_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] mode_i,
   input wire logic soft_enable_i,
   input wire logic sleep_i,
   output logic run_o,
   output logic soft_honored_o
);
   // ****************************************
   // watchdog run decision
   // ****************************************
   always_comb begin
      unique case (mode_i)
         `CWL_WDT_ALWAYS: run_o = 1'b1;
         `CWL_WDT_SOFT: run_o = soft_enable_i;
         `CWL_WDT_RUNONLY: run_o = ~sleep_i;
         `CWL_WDT_OFF: run_o = 1'b0;
      endcase
   end
   assign soft_honored_o = (mode_i == `CWL_WDT_SOFT);

   // ****************************************
   // checks
   // ****************************************
   a_wdt_always_on: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_i == `CWL_WDT_ALWAYS |-> run_o && !soft_honored_o) else $error("watchdog not forced on");
   a_wdt_run_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_i == `CWL_WDT_RUNONLY |-> run_o == !sleep_i) else $error("run-only watchdog wrong in sleep");
   a_wdt_soft_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_i == `CWL_WDT_SOFT && $stable(mode_i) |-> run_o == soft_enable_i) else $error("soft enable ignored");
endmodule
`default_nettype wire

// ===== rtl/cwl_loader.sv
`timescale 1ns/100ps
`default_nettype none
`include "cwl_defs.svh"
module cwl_loader #(
   parameter bit LARGE_DEVICE = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   output logic flash_rd_o,
   output logic flash_wr_o,
   output logic [23:0] flash_addr_o,
   output logic [23:0] flash_wdata_o,
   input wire logic [23:0] flash_rdata_i,
   input wire logic flash_valid_i,
   input wire logic tbl_req_i,
   input wire logic tbl_we_i,
   input wire logic [23:0] tbl_addr_i,
   input wire logic [23:0] tbl_wdata_i,
   output logic tbl_ack_o,
   output logic tbl_err_o,
   output logic [23:0] tbl_rdata_o,
   input wire logic retention_regulator_on_i,
   input wire logic watchdog_soft_enable_i,
   input wire logic sleep_i,
   output logic core_rst_o,
   output logic load_done_o,
   output logic scan_port_enable_o,
   output logic code_protect_o,
   output logic write_protect_o,
   output logic debug_boot_o,
   output logic retention_regulator_o,
   output logic program_pin_pair_one_o,
   output logic program_pin_pair_two_o,
   output logic program_pin_pair_three_o,
   output logic watchdog_run_o,
   output logic watchdog_soft_honored_o,
   output logic window_watchdog_o,
   output logic [7:0] watchdog_prescale_o,
   output logic [15:0] watchdog_postscale_o,
   output logic cfg_error_o
);
   localparam logic [23:0] TOP_ADDR = LARGE_DEVICE ? `CWL_TOP_LARGE : `CWL_TOP_SMALL;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [23:0] word_addr(input logic [1:0] idx);
      word_addr = TOP_ADDR - {21'h000000, idx, 1'b0};
   endfunction

   // hit flag and index of a configuration-space word
   function automatic logic [2:0] cfg_slot(input logic [23:0] addr);
      logic [23:0] off;
      off = addr - `CWL_CFG_BASE;
      cfg_slot = {(off < `CWL_CFG_SPAN) && !off[0], off[2:1]};
   endfunction

   // ****************************************
   // state
   // ****************************************
   cwl_pkg::cwl_state_t state_reg;
   logic [1:0] idx_reg;
   logic [23:0] word_reg [`CWL_NUM_WORDS];
   logic [23:0] addr_reg;
   logic [2:0] slot;
   logic cfg_space;
   logic take;
   cwl_pkg::cwl_cfg_t cfg;

   assign slot = cfg_slot(tbl_addr_i);
   assign cfg_space = tbl_addr_i[`CWL_CFG_SPACE_BIT];
   assign take = (state_reg == cwl_pkg::CWL_RUN) && tbl_req_i;

   // ****************************************
   // fetch sequencer
   // ****************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= cwl_pkg::CWL_FETCH;
         idx_reg <= 2'h0;
      end else if (state_reg == cwl_pkg::CWL_FETCH && flash_valid_i) begin
         idx_reg <= idx_reg + 2'h1;
         if (idx_reg == `CWL_LAST_IDX) begin
            state_reg <= cwl_pkg::CWL_RUN;
         end
      end
   end

   // volatile copy, untouched until the next reset
   generate
      for (genvar g = 0; g < `CWL_NUM_WORDS; g++) begin : g_word
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               word_reg[g] <= 24'hffffff;
            end else if (state_reg == cwl_pkg::CWL_FETCH && flash_valid_i && idx_reg == 2'(g)) begin
               word_reg[g] <= flash_rdata_i;
            end
         end
      end
   endgenerate

   assign flash_rd_o = (state_reg == cwl_pkg::CWL_FETCH);

   // ****************************************
   // flash address and program port
   // ****************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_reg <= TOP_ADDR;
      end else if (state_reg == cwl_pkg::CWL_FETCH && flash_valid_i) begin
         addr_reg <= word_addr(idx_reg + 2'h1);
      end else if (take && tbl_we_i && slot[2]) begin
         addr_reg <= word_addr(slot[1:0]);
      end
   end
   assign flash_addr_o = addr_reg;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flash_wr_o <= 1'b0;
         flash_wdata_o <= 24'h000000;
      end else begin
         flash_wr_o <= take && tbl_we_i && slot[2] && !cfg.write_protect;
         if (take && tbl_we_i && slot[2]) begin
            flash_wdata_o <= {`CWL_UPPER_NOP, tbl_wdata_i[`CWL_LOW_HI:0]};
         end
      end
   end

   // ****************************************
   // table access port
   // ****************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tbl_ack_o <= 1'b0;
         tbl_err_o <= 1'b0;
         tbl_rdata_o <= 24'h000000;
      end else begin
         tbl_ack_o <= take;
         tbl_err_o <= take && (!cfg_space || (tbl_we_i && (!slot[2] || cfg.write_protect)));
         if (take && !tbl_we_i) begin
            if (slot[2]) begin
               tbl_rdata_o <= {`CWL_UPPER_ONES, word_reg[slot[1:0]][`CWL_LOW_HI:0]};
            end else begin
               tbl_rdata_o <= 24'h000000;
            end
         end
      end
   end

   // ****************************************
   // decode and outputs
   // ****************************************
   cwl_word_decode u_decode (
      .word_i(word_reg[0]),
      .cfg_o(cfg)
   );

   cwl_wdt_ctrl u_wdt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .mode_i(cfg.watchdog_mode_cfg),
      .soft_enable_i(watchdog_soft_enable_i),
      .sleep_i(sleep_i),
      .run_o(watchdog_run_o),
      .soft_honored_o(watchdog_soft_honored_o)
   );

   assign load_done_o = (state_reg == cwl_pkg::CWL_RUN);
   assign core_rst_o = !load_done_o;
   assign scan_port_enable_o = load_done_o && cfg.scan_port_enable;
   assign code_protect_o = cfg.code_protect;
   assign write_protect_o = cfg.write_protect;
   assign debug_boot_o = cfg.debug_boot;
   assign retention_regulator_o = cfg.retention_fw_ctl && retention_regulator_on_i;
   assign program_pin_pair_one_o = cfg.emu_pair[0];
   assign program_pin_pair_two_o = cfg.emu_pair[1];
   assign program_pin_pair_three_o = cfg.emu_pair[2];
   assign window_watchdog_o = cfg.window_sel && (cfg.watchdog_mode_cfg != `CWL_WDT_OFF);
   assign watchdog_prescale_o = cfg.prescale_ratio;
   assign watchdog_postscale_o = cfg.postscale_ratio;
   assign cfg_error_o = load_done_o && cfg.cfg_error;

   // ****************************************
   // checks
   // ****************************************
   a_core_held_load: assert property (@(posedge clk_i) disable iff (rst_i)
      !load_done_o |-> core_rst_o && flash_rd_o && !tbl_ack_o) else $error("core released early");
   a_first_fetch_top: assert property (@(posedge clk_i) disable iff (rst_i)
      flash_rd_o && idx_reg == 2'h0 |-> flash_addr_o == TOP_ADDR) else $error("first fetch not at top");
   a_fetch_step_down: assert property (@(posedge clk_i) disable iff (rst_i)
      flash_rd_o && flash_valid_i && idx_reg != 2'h3 |=> flash_addr_o == $past(flash_addr_o) - 24'h000002)
      else $error("fetch address step wrong");
   a_load_after_four: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(load_done_o) |-> $past(flash_valid_i) && $past(idx_reg) == 2'h3) else $error("load ended early");
   a_upper_reads_ones: assert property (@(posedge clk_i) disable iff (rst_i)
      take && !tbl_we_i && slot[2] |=> tbl_ack_o && tbl_rdata_o[23:16] == 8'hff) else $error("upper byte not ones");
   a_code_prot_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      load_done_o |-> code_protect_o == !word_reg[0][13] && write_protect_o == !word_reg[0][12])
      else $error("protection decode wrong");
   a_write_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
      take && tbl_we_i && word_reg[0][12] == 1'b0 |=> !flash_wr_o && tbl_err_o) else $error("protected write passed");
   a_write_upper_nop: assert property (@(posedge clk_i) disable iff (rst_i)
      flash_wr_o |-> flash_wdata_o[23:16] == 8'h00) else $error("upper byte not zero");
   a_outside_refused: assert property (@(posedge clk_i) disable iff (rst_i)
      take && !tbl_addr_i[23] |=> tbl_err_o && !flash_wr_o) else $error("non config access accepted");
   a_scan_port_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      load_done_o |-> scan_port_enable_o == word_reg[0][14] && debug_boot_o == !word_reg[0][11])
      else $error("scan or debug decode wrong");
   a_emu_pair_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
      load_done_o && word_reg[0][9:8] == 2'h2 |-> program_pin_pair_two_o && !program_pin_pair_one_o)
      else $error("emulator pair wrong");
   a_window_gated: assert property (@(posedge clk_i) disable iff (rst_i)
      word_reg[0][7:6] == 2'h0 |-> !window_watchdog_o) else $error("window with watchdog off");
   a_prescale_ratio: assert property (@(posedge clk_i) disable iff (rst_i)
      load_done_o |-> watchdog_prescale_o == (word_reg[0][4] ? 8'h80 : 8'h20)) else $error("prescale wrong");
   a_postscale_max: assert property (@(posedge clk_i) disable iff (rst_i)
      load_done_o && word_reg[0][3:0] == 4'hf |-> watchdog_postscale_o == 16'h8000) else $error("postscale wrong");
   a_retention_off: assert property (@(posedge clk_i) disable iff (rst_i)
      word_reg[0][10] |-> !retention_regulator_o) else $error("retention regulator on");
endmodule
`default_nettype wire

// ===== bench/cwl_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// flash array holding the four configuration words
// ****
module cwl_flash_model #(
   parameter logic [23:0] TOP = 24'h0157fe
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [23:0] addr_i,
   input wire logic [23:0] wdata_i,
   output logic [23:0] rdata_o,
   output logic valid_o
);
   logic [23:0] mem [4] = '{default: 24'hffffff};
   logic [23:0] seen [4];
   logic [1:0] idx;
   int lag = 0;
   int wait_cnt;
   int n_seen;
   // slot 0 sits at the top address, then down by two
   assign idx = 2'((TOP - addr_i) >> 1);
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         valid_o <= 1'b0;
         wait_cnt <= 0;
         n_seen <= 0;
         rdata_o <= 24'h5a5a5a;
      end else if (valid_o) begin
         valid_o <= 1'b0;
         wait_cnt <= 0;
         rdata_o <= ~rdata_o;
      end else if (rd_i && wait_cnt >= lag) begin
         valid_o <= 1'b1;
         rdata_o <= mem[idx];
         seen[n_seen[1:0]] <= addr_i;
         n_seen <= n_seen + 1;
      end else begin
         rdata_o <= ~rdata_o;
         if (rd_i)
            wait_cnt <= wait_cnt + 1;
      end
      if (!rst_i && wr_i)
         mem[idx] <= wdata_i;
   end
endmodule
`default_nettype wire

// ===== bench/cwl_loader_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cwl_loader_tb_top;
   localparam logic [23:0] TOP = 24'h0157fe;
   logic clk_i, rst_i, flash_rd_o, flash_wr_o, flash_valid_i, tbl_req_i, tbl_we_i, tbl_ack_o, tbl_err_o;
   logic [23:0] flash_addr_o, flash_wdata_o, flash_rdata_i, tbl_addr_i, tbl_wdata_i, tbl_rdata_o;
   logic retention_regulator_on_i, watchdog_soft_enable_i, sleep_i, core_rst_o, load_done_o;
   logic scan_port_enable_o, code_protect_o, write_protect_o, debug_boot_o, retention_regulator_o;
   logic program_pin_pair_one_o, program_pin_pair_two_o, program_pin_pair_three_o, cfg_error_o;
   logic watchdog_run_o, watchdog_soft_honored_o, window_watchdog_o;
   logic [7:0] watchdog_prescale_o;
   logic [15:0] watchdog_postscale_o;
   logic [23:0] small_addr;
   logic [35:0] dec;
   logic [23:0] words [5] = '{24'hffffff, 24'h003283, 24'hff4d7f, 24'h000000, 24'h006b20};
   int fail_count, tests_run, cycles;
   assign dec = {scan_port_enable_o, code_protect_o, write_protect_o, debug_boot_o, retention_regulator_o,
      program_pin_pair_one_o, program_pin_pair_two_o, program_pin_pair_three_o, watchdog_run_o,
      watchdog_soft_honored_o, window_watchdog_o, watchdog_prescale_o, watchdog_postscale_o, cfg_error_o};
   cwl_loader #(.LARGE_DEVICE(1'b1)) dut (
      .clk_i, .rst_i, .flash_rd_o, .flash_wr_o, .flash_addr_o, .flash_wdata_o, .flash_rdata_i,
      .flash_valid_i, .tbl_req_i, .tbl_we_i, .tbl_addr_i, .tbl_wdata_i, .tbl_ack_o, .tbl_err_o,
      .tbl_rdata_o, .retention_regulator_on_i, .watchdog_soft_enable_i, .sleep_i, .core_rst_o,
      .load_done_o, .scan_port_enable_o, .code_protect_o, .write_protect_o, .debug_boot_o,
      .retention_regulator_o, .program_pin_pair_one_o, .program_pin_pair_two_o,
      .program_pin_pair_three_o, .watchdog_run_o, .watchdog_soft_honored_o, .window_watchdog_o,
      .watchdog_prescale_o, .watchdog_postscale_o, .cfg_error_o);
   // smaller variant shares the flash answers, only its fetch address is watched
   cwl_loader #(.LARGE_DEVICE(1'b0)) dut_small (
      .clk_i, .rst_i, .flash_rd_o(), .flash_wr_o(), .flash_addr_o(small_addr), .flash_wdata_o(),
      .flash_rdata_i, .flash_valid_i, .tbl_req_i, .tbl_we_i, .tbl_addr_i, .tbl_wdata_i, .tbl_ack_o(),
      .tbl_err_o(), .tbl_rdata_o(), .retention_regulator_on_i, .watchdog_soft_enable_i, .sleep_i,
      .core_rst_o(), .load_done_o(), .scan_port_enable_o(), .code_protect_o(), .write_protect_o(),
      .debug_boot_o(), .retention_regulator_o(), .program_pin_pair_one_o(), .program_pin_pair_two_o(),
      .program_pin_pair_three_o(), .watchdog_run_o(), .watchdog_soft_honored_o(), .window_watchdog_o(),
      .watchdog_prescale_o(), .watchdog_postscale_o(), .cfg_error_o());
   cwl_flash_model #(.TOP(TOP)) flash (
      .clk_i, .rst_i, .rd_i(flash_rd_o), .wr_i(flash_wr_o), .addr_i(flash_addr_o),
      .wdata_i(flash_wdata_o), .rdata_o(flash_rdata_i), .valid_o(flash_valid_i));
   // ****
   // helpers
   // ****
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [35:0] exp_dec(input logic [23:0] w, input logic [2:0] in);
      logic [1:0] m;
      logic run;
      m = w[7:6];
      run = (m == 2'h3) | ((m == 2'h2) & in[1]) | ((m == 2'h1) & ~in[0]);
      return {w[14], ~w[13], ~w[12], ~w[11], ~w[10] & in[2], w[9:8] == 2'h3, w[9:8] == 2'h2,
         w[9:8] == 2'h1, run, m == 2'h2, ~w[5] & (m != 2'h0), w[4] ? 8'h80 : 8'h20,
         16'h0001 << w[3:0], (w[9:8] == 2'h0) | (~w[5] & (m == 2'h0))};
   endfunction
   task automatic tbl(input logic we, input logic [23:0] a, input logic [23:0] d);
      @(posedge clk_i);
      tbl_req_i <= 1'b1;
      tbl_we_i <= we;
      tbl_addr_i <= a;
      tbl_wdata_i <= d;
      @(posedge clk_i);
      tbl_req_i <= 1'b0;
      #1;
   endtask
   task automatic load(input int lagv);
      int k;
      flash.lag = lagv;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk({core_rst_o, load_done_o, flash_rd_o, flash_addr_o}, {3'b101, TOP});
      chk(small_addr, 24'h00abfe);
      if (lagv > 2) begin
         tbl(1'b0, 24'hf80000, 24'h0);
         chk({tbl_ack_o, core_rst_o}, 2'b01);
      end
      k = 0;
      while (load_done_o !== 1'b1 && k < 200) begin
         @(posedge clk_i);
         #1;
         k++;
      end
      chk({load_done_o, core_rst_o}, 2'b10);
      chk({flash.seen[0], flash.seen[1], flash.seen[2], flash.seen[3]},
         {TOP, TOP - 24'h2, TOP - 24'h4, TOP - 24'h6});
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      rst_i = 1'b1;
      {tbl_req_i, tbl_we_i, tbl_addr_i, tbl_wdata_i} = '0;
      {retention_regulator_on_i, watchdog_soft_enable_i, sleep_i} = 3'h0;
      fail_count = 0;
      tests_run = 0;
      cycles = 0;
      flash.mem[2] = 24'h00a5c3;
      flash.mem[3] = 24'h000f0f;
      for (int i = 0; i < 5; i++) begin
         flash.mem[0] = words[i];
         load(i);
         for (int j = 0; j < 8; j++) begin
            @(posedge clk_i);
            {retention_regulator_on_i, watchdog_soft_enable_i, sleep_i} <= j[2:0];
            @(posedge clk_i);
            #1;
            chk(dec, exp_dec(words[i], j[2:0]));
         end
         tbl(1'b0, 24'hf80000, 24'h0);
         chk({tbl_ack_o, tbl_err_o, tbl_rdata_o}, {2'b10, 8'hff, words[i][15:0]});
      end
      tbl(1'b1, 24'hf80002, 24'h001111);
      chk({tbl_ack_o, tbl_err_o, flash_wr_o}, 3'b110);
      flash.mem[0] = 24'h003283;
      load(0);
      tbl(1'b1, 24'hf80002, 24'hff5a5a);
      chk({tbl_ack_o, tbl_err_o, flash_wr_o, flash_addr_o, flash_wdata_o}, {3'b101, TOP - 24'h2, 24'h005a5a});
      tbl(1'b0, 24'hf80002, 24'h0);
      chk(tbl_rdata_o, 24'hffffff);
      load(3);
      for (int k = 1; k < 4; k++) begin
         tbl(1'b0, 24'hf80000 + 24'(2 * k), 24'h0);
         chk({tbl_ack_o, tbl_rdata_o}, {1'b1, 8'hff, flash.mem[k][15:0]});
      end
      tbl(1'b0, 24'hf80010, 24'h0);
      chk({tbl_ack_o, tbl_err_o, tbl_rdata_o}, {2'b10, 24'h0});
      tbl(1'b0, 24'h000100, 24'h0);
      chk({tbl_ack_o, tbl_err_o}, 2'b11);
      tbl(1'b1, 24'hf80010, 24'h000001);
      chk({tbl_ack_o, tbl_err_o, flash_wr_o}, 3'b110);
      wrap_up();
   end
endmodule
`default_nettype wire
